// ==== design/irq_enable_bank.sv ====
// Interrupt enable registers for groups three and five with request gating
`timescale 1ns/1ps
module irq_enable_bank
    import irq_enable_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic [ADDR_W-1:0]      reg_addr,
    input  wire logic [REG_W-1:0]       reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [REG_W-1:0]       reg_rdata,
    input  wire logic [NUM_SOURCES-1:0] source_event,
    output logic      [NUM_SOURCES-1:0] irq_request
);

    typedef struct packed {
        logic [REG_W-1:0] group_three;
        logic [REG_W-1:0] wakeup_group;
        logic [REG_W-1:0] rdata;
    } bank_state_type;

    bank_state_type state_q;
    bank_state_type state_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Register port

    always_comb begin
        state_d       = state_q;
        state_d.rdata = READ_IDLE;
        if (reg_wr && reg_addr == GROUP_THREE_ADDR) begin
            state_d.group_three = reg_wdata & GROUP_THREE_MASK;
        end else if (reg_wr && reg_addr == WAKEUP_GROUP_ADDR) begin
            state_d.wakeup_group = reg_wdata & WAKEUP_GROUP_MASK;
        end
        if (reg_rd && reg_addr == GROUP_THREE_ADDR) begin
            state_d.rdata = state_q.group_three;
        end else if (reg_rd && reg_addr == WAKEUP_GROUP_ADDR) begin
            state_d.rdata = state_q.wakeup_group;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q.group_three  <= ENABLE_RESET;
            state_q.wakeup_group <= ENABLE_RESET;
            state_q.rdata        <= READ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Request gating

    irq_gate_if #(.N(NUM_SOURCES)) gif ();

    always_comb begin
        gif.enable                     = REQUEST_RESET;
        gif.enable[SRC_CHARGE_TIME]    = state_q.group_three[CHARGE_TIME_BIT];
        gif.enable[SRC_VOLTAGE_DETECT] = state_q.group_three[VOLTAGE_DETECT_BIT];
        gif.enable[SRC_CHECKSUM]       = state_q.group_three[CHECKSUM_BIT];
        gif.enable[SRC_SECOND_SERIAL]  = state_q.group_three[SECOND_SERIAL_BIT];
        gif.enable[SRC_FIRST_SERIAL]   = state_q.group_three[FIRST_SERIAL_BIT];
        gif.enable[SRC_LOW_POWER_WAKE] = state_q.wakeup_group[LOW_POWER_WAKEUP_BIT];
    end

    assign gif.evt_in  = source_event;
    assign irq_request = gif.request;

    irq_request_gate u_gate (
        .clk   (clk),
        .rst_b (rst_b),
        .gif   (gif)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    charge_bit_write_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (reg_wr && reg_addr == GROUP_THREE_ADDR)
        |=> (state_q.group_three == ($past(reg_wdata) & GROUP_THREE_MASK)))
        else $error("group three did not take the written implemented bits");

    group_three_read_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (reg_rd && reg_addr == GROUP_THREE_ADDR)
        |=> ((reg_rdata & ~GROUP_THREE_MASK) == READ_IDLE))
        else $error("unimplemented group three bit read as one");

    wakeup_bit_write_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (reg_wr && reg_addr == WAKEUP_GROUP_ADDR) ##1 (reg_rd && reg_addr == WAKEUP_GROUP_ADDR)
        |=> (reg_rdata[LOW_POWER_WAKEUP_BIT] == $past(reg_wdata[LOW_POWER_WAKEUP_BIT], 2)))
        else $error("wake-up enable did not read back as written");

    wakeup_upper_zero_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (reg_rd && reg_addr == WAKEUP_GROUP_ADDR)
        |=> ((reg_rdata & ~WAKEUP_GROUP_MASK) == READ_IDLE))
        else $error("unimplemented wake-up group bit read as one");

    reset_clears_a: assert property (
        @(posedge clk)
        !rst_b |=> (state_q.group_three == ENABLE_RESET && state_q.wakeup_group == ENABLE_RESET))
        else $error("enable bits not cleared by reset");

endmodule

// ==== design/irq_enable_pkg.sv ====
// Constants for the interrupt enable bank, groups three and five
// Behaviour
// - A set enable bit lets its peripheral's event raise an interrupt request.
// - A clear enable bit blocks its peripheral's request even while the event is present.
// - Group three: charge-time bit 13, voltage-detect 8, checksum 3, serial errors 2 and 1.
// - Group five implements only bit 0, read/write low-power wake-up enable.
// - Group five bits 15 to 1 read as zero and ignore writes.
package irq_enable_pkg;

    localparam int          REG_W       = 16;
    localparam int          ADDR_W      = 4;
    localparam int          NUM_SOURCES = 6;

    // Register addresses on the register port
    localparam logic [3:0]  GROUP_THREE_ADDR = 4'h0;
    localparam logic [3:0]  WAKEUP_GROUP_ADDR = 4'h1;

    // Bit positions inside the registers
    localparam int          CHARGE_TIME_BIT     = 13;
    localparam int          VOLTAGE_DETECT_BIT  = 8;
    localparam int          CHECKSUM_BIT        = 3;
    localparam int          SECOND_SERIAL_BIT   = 2;
    localparam int          FIRST_SERIAL_BIT    = 1;
    localparam int          LOW_POWER_WAKEUP_BIT = 0;

    // Implemented bits of each register, enable reset value and idle read value
    localparam logic [15:0] GROUP_THREE_MASK = 16'h210E;
    localparam logic [15:0] WAKEUP_GROUP_MASK = 16'h0001;
    localparam logic [15:0] ENABLE_RESET     = 16'h0000;
    localparam logic [15:0] READ_IDLE        = 16'h0000;

    // Index of each source on the event and request vectors
    localparam int          SRC_CHARGE_TIME    = 0;
    localparam int          SRC_VOLTAGE_DETECT = 1;
    localparam int          SRC_CHECKSUM       = 2;
    localparam int          SRC_SECOND_SERIAL  = 3;
    localparam int          SRC_FIRST_SERIAL   = 4;
    localparam int          SRC_LOW_POWER_WAKE = 5;

    localparam logic [5:0]  REQUEST_RESET = 6'h00;

endpackage

// ==== design/irq_gate_if.sv ====
// Interface between the enable registers and the request gate
`timescale 1ns/1ps
interface irq_gate_if #(parameter int N = 6);
    logic [N-1:0] enable;
    logic [N-1:0] evt_in;
    logic [N-1:0] request;

    modport ctrl (output enable, output evt_in, input request);
    modport gate (input enable, input evt_in, output request);
endinterface

// ==== design/irq_request_gate.sv ====
// Gates peripheral events with their enable bits into registered requests
`timescale 1ns/1ps
module irq_request_gate
    import irq_enable_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    irq_gate_if.gate  gif
);

    typedef struct packed {
        logic [NUM_SOURCES-1:0] req;
    } gate_state_type;

    gate_state_type state_q;
    gate_state_type state_d;
    logic [NUM_SOURCES-1:0] allowed;
    logic [NUM_SOURCES-1:0] blocked;

    assign allowed = gif.enable & gif.evt_in;
    assign blocked = ~gif.enable;

    always_comb begin
        state_d     = state_q;
        state_d.req = allowed;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q.req <= REQUEST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign gif.request = state_q.req;

    request_passes_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (|allowed) |=> ((gif.request & $past(allowed)) == $past(allowed)))
        else $error("enabled event did not raise its request");

    request_blocked_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (|blocked) |=> ((gif.request & $past(blocked)) == REQUEST_RESET))
        else $error("request raised while its enable was clear");

endmodule

// ==== testbench/irq_enable_bank_test.sv ====
// Self-checking bench for the interrupt enable bank
`timescale 1ns/1ps
module irq_enable_bank_test;
    import irq_enable_pkg::*;

    logic                   clk;
    logic                   rst_b;
    logic [ADDR_W-1:0]      reg_addr;
    logic [REG_W-1:0]       reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [REG_W-1:0]       reg_rdata;
    logic [NUM_SOURCES-1:0] source_event;
    logic [NUM_SOURCES-1:0] irq_request;
    int                     failures;
    int                     checked;
    int                     bitpos [6] = '{13, 8, 3, 2, 1, 0};

    irq_enable_bank u_irq_enable_bank (
        .clk          (clk),
        .rst_b        (rst_b),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_rdata    (reg_rdata),
        .source_event (source_event),
        .irq_request  (irq_request)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    task automatic req(input logic [5:0] e);
        @(posedge clk);
        #1 chk({10'h000, irq_request}, {10'h000, e});
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        failures++;
        give_verdict();
    end

    initial begin
        failures = 0;
        checked = 0;
        rst_b = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        source_event = 6'h3F;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        req(6'h00);
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0000);
        $display("Test reset done");
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'h210E);
        wr(4'h1, 16'hFFFF);
        rd(4'h1, 16'h0001);
        wr(4'h1, 16'hFFFE);
        rd(4'h1, 16'h0000);
        // Write straight into a read with no gap between the strobes
        @(posedge clk);
        reg_addr  <= 4'h1;
        reg_wdata <= 16'hFFFF;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk);
        reg_rd    <= 1'b0;
        #1 chk(reg_rdata, 16'h0001);
        wr(4'h2, 16'hFFFF);
        rd(4'h2, 16'h0000);
        @(posedge clk);
        #1 chk(reg_rdata, 16'h0000);
        $display("Test register map done");
        for (int i = 0; i < 6; i++) begin
            wr(4'h0, (i < 5) ? (16'h0001 << bitpos[i]) : 16'h0000);
            wr(4'h1, (i == 5) ? 16'h0001 : 16'h0000);
            req(6'h01 << i);
        end
        wr(4'h0, 16'h210E);
        req(6'h3F);
        // Events drop at an edge; the request follows one cycle later
        @(posedge clk);
        source_event <= 6'h15;
        #1 chk({10'h000, irq_request}, 16'h003F);
        req(6'h15);
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h0000);
        source_event <= 6'h3F;
        req(6'h00);
        req(6'h00);
        $display("Test request gating done");
        wr(4'h0, 16'h210E);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        req(6'h00);
        rd(4'h0, 16'h0000);
        $display("Test second reset done");
        give_verdict();
    end
endmodule
